//--- src/dls_pkg.sv
// Constants for the DSL link supervisor and loop/pattern test logic.
// Assumes a single 125 MHz clock; timers run on a 1 ms tick.
package dls_pkg;
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned TICK_US        = 1000;
  localparam int unsigned TICK_CYC       = CLK_MHZ * TICK_US;
  localparam int unsigned MS_PER_S       = 1000;
  // Restart limits and pattern validity, in seconds
  localparam int unsigned STARTUP_S      = 50;
  localparam int unsigned DATA_S         = 4;
  localparam int unsigned PATTERN_LIM_S  = 60;
  localparam int unsigned REMOTE_LIM_S   = 60;
  localparam int unsigned PAT_TIMEOUT_S  = 45;
  localparam logic [15:0] LIM_STARTUP    = 16'(STARTUP_S * MS_PER_S);
  localparam logic [15:0] LIM_DATA       = 16'(DATA_S * MS_PER_S);
  localparam logic [15:0] LIM_PATTERN    = 16'(PATTERN_LIM_S * MS_PER_S);
  localparam logic [15:0] LIM_REMOTE     = 16'(REMOTE_LIM_S * MS_PER_S);
  localparam logic [15:0] LIM_PAT_TO     = 16'(PAT_TIMEOUT_S * MS_PER_S);
  // Error indicator cadence, in ms
  localparam logic [15:0] FLASH_MS       = 16'd100;
  localparam logic [15:0] BLINK_MS       = 16'd250;
  // Register byte offsets
  localparam logic [3:0]  ADDR_CTRL      = 4'h0;
  localparam logic [3:0]  ADDR_STATUS    = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_STAT  = 4'h8;
  localparam logic [3:0]  ADDR_IRQ_MASK  = 4'hc;
  // Control fields
  localparam int unsigned CTRL_LOCAL     = 0;
  localparam int unsigned CTRL_PAT       = 1;
  localparam int unsigned CTRL_PAT_ERR   = 2;
  localparam int unsigned CTRL_REMOTE    = 3;
  localparam int unsigned CTRL_W         = 4;
  // Interrupt event fields
  localparam int unsigned EV_RESTART     = 0;
  localparam int unsigned EV_CRC         = 1;
  localparam int unsigned EV_BITERR      = 2;
  localparam int unsigned EV_PAT_TO      = 3;
  localparam int unsigned EV_LINK_UP     = 4;
  localparam int unsigned EV_W           = 5;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [8:0]  PRBS_SEED      = 9'h1ff;
  localparam logic [3:0]  PRBS_FILL      = 4'h9;
  typedef enum logic [1:0] {LOOP_NONE, LOOP_M1, LOOP_M2} dls_loop_e;
  typedef enum logic {LINK_STARTUP, LINK_DATA} dls_link_e;
endpackage

//--- src/dls_supervisor.sv
// Link supervision, loop control and 511/511E pattern test for a DSL card.
// Bit streams are qualified by one-cycle valid strobes in the mclk domain.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none
module dls_supervisor #(
  parameter int unsigned TICK_CYCLES = dls_pkg::TICK_CYC, // mclk cycles per ms
  parameter int unsigned ERR_GAP     = 256              // 511E bits per error
) (
  input  wire logic        mclk,                  // 125 MHz clock
  input  wire logic        rst,                   // Async reset, high
  input  wire logic [3:0]  s_axi_awaddr,          // Write address
  input  wire logic        s_axi_awvalid,         // Write address valid
  output logic             s_axi_awready,         // Write address ready
  input  wire logic [31:0] s_axi_wdata,           // Write data
  input  wire logic [3:0]  s_axi_wstrb,           // Write strobes
  input  wire logic        s_axi_wvalid,          // Write data valid
  output logic             s_axi_wready,          // Write data ready
  output logic [1:0]       s_axi_bresp,           // Write response
  output logic             s_axi_bvalid,          // Write response valid
  input  wire logic        s_axi_bready,          // Write response ready
  input  wire logic [3:0]  s_axi_araddr,          // Read address
  input  wire logic        s_axi_arvalid,         // Read address valid
  output logic             s_axi_arready,         // Read address ready
  output logic [31:0]      s_axi_rdata,           // Read data
  output logic [1:0]       s_axi_rresp,           // Read response
  output logic             s_axi_rvalid,          // Read data valid
  input  wire logic        s_axi_rready,          // Read data ready
  input  wire logic        swLocalLoop,           // Panel local loop switch
  input  wire logic        dteLocalLoop,          // Terminal local loop line
  input  wire logic        swRemoteLoop,          // Panel remote loop switch
  input  wire logic        dteRemoteLoop,         // Terminal remote loop line
  input  wire logic        swPattern,             // Panel 511 switch
  input  wire logic        swPatternErr,          // Panel 511E position
  input  wire logic        remoteLoopActive,      // Unit is far end of remote loop
  input  wire logic        lineRxPkt,             // Packet received, pulse
  input  wire logic        lineRxFramed,          // Packet carried framing
  input  wire logic        crcErr,                // CRC error, pulse
  input  wire logic        lineRxValid,           // Line receive bit strobe
  input  wire logic        lineRxBit,             // Line receive bit
  input  wire logic        lineTxStrobe,          // Line transmit bit slot
  input  wire logic        dteTxValid,            // Terminal transmit strobe
  input  wire logic        dteTxBit,              // Terminal transmit bit
  output logic             lineTxValid,           // Line transmit strobe
  output logic             lineTxBit,             // Line transmit bit
  output logic             lineTxFramed,          // Bit goes through framer
  output logic             dteRxValid,            // Terminal receive strobe
  output logic             dteRxBit,              // Terminal receive bit
  output logic             clearToSend,           // CTS to terminal
  output logic             carrierDetect,         // CD to terminal
  output logic             noLinkIndicator,       // Link down lamp
  output logic             errorIndicator,        // Error lamp
  output logic             testMode,              // Test mode lamp
  output logic             remoteLoopbackRequest, // Remote loop request
  output logic             linkRestart,           // Restart pulse
  output logic             irq                    // Level interrupt
);
  import dls_pkg::*;

  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);
  localparam logic [7:0]  GAP_LAST  = 8'(ERR_GAP - 1);

  logic [16:0]          tickCnt;
  logic                 tick;
  logic [CTRL_W-1:0]    ctrl;
  logic [EV_W-1:0]      irqStatus;
  logic [EV_W-1:0]      irqMask;
  logic [EV_W-1:0]      events;
  logic [3:0]           awAddr;
  logic [31:0]          wData;
  logic [3:0]           wStrb;
  logic                 doWrite;
  logic                 doRead;
  logic                 framedNow;
  logic [15:0]          unfrMs;
  logic [15:0]          restartLim;
  logic                 restartHit;
  dls_link_e            link;
  dls_loop_e            loopMode;
  logic                 localReq;
  logic                 localReqQ;
  logic                 patReq;
  logic                 patReqQ;
  logic                 patActive;
  logic                 patTimedOut;
  logic                 patExpire;
  logic [15:0]          patMs;
  logic [8:0]           gen;
  logic [7:0]           gapCnt;
  logic                 genBit;
  logic                 genStep;
  logic [8:0]           det;
  logic [3:0]           detFill;
  logic                 detValid;
  logic                 detBit;
  logic                 bitErr;
  logic                 crcEvt;
  logic [15:0]          lampMs;
  logic                 lampOn;
  logic                 linkUpEvt;

  // Restart limit selection by state
  function automatic logic [15:0] limit_of(input logic pat, input logic rem,
                                           input dls_link_e lk);
    if (pat) begin
      limit_of = LIM_PATTERN;
    end else if (rem) begin
      limit_of = LIM_REMOTE;
    end else if (lk == LINK_STARTUP) begin
      limit_of = LIM_STARTUP;
    end else begin
      limit_of = LIM_DATA;
    end
  endfunction

  // Free-running 1 ms tick
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tickCnt <= '0;
      tick    <= 1'b0;
    end else begin
      tick    <= (tickCnt == TICK_LAST);
      tickCnt <= (tickCnt == TICK_LAST) ? '0 : tickCnt + 17'd1;
    end
  end

  // AXI4-Lite: address and data taken in either order, response after both
  assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign doRead  = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awAddr        <= '0;
      wData         <= '0;
      wStrb         <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awAddr        <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        if (awAddr == ADDR_CTRL || awAddr == ADDR_IRQ_MASK ||
            awAddr == ADDR_STATUS || awAddr == ADDR_IRQ_STAT) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl    <= '0;
      irqMask <= '0;
    end else if (doWrite && wStrb[0]) begin
      if (awAddr == ADDR_CTRL) begin
        ctrl <= wData[CTRL_W-1:0];
      end else if (awAddr == ADDR_IRQ_MASK) begin
        irqMask <= wData[EV_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (doRead) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      if (s_axi_araddr == ADDR_CTRL) begin
        s_axi_rdata <= {28'h0, ctrl};
      end else if (s_axi_araddr == ADDR_STATUS) begin
        s_axi_rdata <= {26'h0, patTimedOut, patActive, loopMode,
                        framedNow, link == LINK_DATA};
      end else if (s_axi_araddr == ADDR_IRQ_STAT) begin
        s_axi_rdata <= {27'h0, irqStatus};
      end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
        s_axi_rdata <= {27'h0, irqMask};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Sticky events; a new event wins over the read clear
  assign events = {linkUpEvt, patExpire, bitErr, crcEvt, restartHit};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irqStatus <= '0;
      irq       <= 1'b0;
    end else begin
      if (doRead && s_axi_araddr == ADDR_IRQ_STAT) begin
        irqStatus <= events;
      end else begin
        irqStatus <= irqStatus | events;
      end
      irq <= |(irqStatus & irqMask);
    end
  end

  // Framer status: last packet decides framed or not
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      framedNow     <= 1'b0;
      clearToSend   <= 1'b0;
      carrierDetect <= 1'b0;
    end else begin
      if (lineRxPkt) begin
        framedNow <= lineRxFramed;
      end
      // Line data is invalid in mode 1, so the framer sees no frames
      clearToSend   <= framedNow && loopMode != LOOP_M1;
      carrierDetect <= framedNow && loopMode != LOOP_M1;
    end
  end

  // Consecutive unframed time, reset by any framed packet outside mode 1
  assign restartLim = limit_of(patActive, remoteLoopActive, link);
  assign restartHit = tick && (unfrMs >= restartLim - 16'd1);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      unfrMs <= '0;
    end else if (framedNow && loopMode != LOOP_M1) begin
      unfrMs <= '0;
    end else if (restartHit) begin
      unfrMs <= '0;
    end else if (tick) begin
      unfrMs <= unfrMs + 16'd1;
    end
  end

  // Link state
  assign linkUpEvt = link == LINK_STARTUP && framedNow && loopMode != LOOP_M1;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link            <= LINK_STARTUP;
      linkRestart     <= 1'b0;
      noLinkIndicator <= 1'b1;
    end else begin
      linkRestart <= restartHit;
      if (restartHit) begin
        link <= LINK_STARTUP;
      end else if (loopMode == LOOP_M1 && !localReq) begin
        link <= LINK_STARTUP;
      end else if (linkUpEvt) begin
        link <= LINK_DATA;
      end
      noLinkIndicator <= link == LINK_STARTUP;
    end
  end

  // Loop control requests
  assign localReq = swLocalLoop || dteLocalLoop || ctrl[CTRL_LOCAL];
  assign patReq   = swPattern || ctrl[CTRL_PAT];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      localReqQ <= 1'b0;
      loopMode  <= LOOP_NONE;
    end else begin
      localReqQ <= localReq;
      if (!localReq) begin
        loopMode <= LOOP_NONE;
      end else if (!localReqQ) begin
        loopMode <= (link == LINK_DATA) ? LOOP_M2 : LOOP_M1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      remoteLoopbackRequest <= 1'b0;
      testMode              <= 1'b0;
    end else begin
      remoteLoopbackRequest <= swRemoteLoop || dteRemoteLoop || ctrl[CTRL_REMOTE];
      testMode <= loopMode != LOOP_NONE || patActive || remoteLoopActive;
    end
  end

  // Pattern generator enable and validity timer
  assign patExpire = patActive && tick && (patMs >= LIM_PAT_TO - 16'd1);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      patReqQ     <= 1'b0;
      patActive   <= 1'b0;
      patTimedOut <= 1'b0;
      patMs       <= '0;
    end else begin
      patReqQ <= patReq;
      if (!patReq) begin
        patActive   <= 1'b0;
        patTimedOut <= 1'b0;
      end else if (loopMode == LOOP_M2) begin
        patActive <= 1'b0;
      end else if (!patReqQ) begin
        patActive <= 1'b1;
        patMs     <= '0;
      end else if (patExpire) begin
        patActive   <= 1'b0;
        patTimedOut <= 1'b1;
      end else if (patActive && tick) begin
        patMs <= patMs + 16'd1;
      end
    end
  end

  // 511 sequence, x^9 + x^5 + 1; 511E inverts one bit per gap
  assign genStep = patActive && lineTxStrobe;
  assign genBit  = gen[8] ^ gen[4] ^
                   ((swPatternErr || ctrl[CTRL_PAT_ERR]) && gapCnt == GAP_LAST);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gen    <= PRBS_SEED;
      gapCnt <= '0;
    end else if (genStep) begin
      gen    <= {gen[7:0], gen[8] ^ gen[4]};
      gapCnt <= (gapCnt == GAP_LAST) ? '0 : gapCnt + 8'd1;
    end
  end

  // Detector: mode 1 takes the generator directly, else the line
  assign detValid = patActive && ((loopMode == LOOP_M1) ? genStep : lineRxValid);
  assign detBit   = (loopMode == LOOP_M1) ? genBit : lineRxBit;
  assign bitErr   = detValid && detFill == PRBS_FILL && detBit != (det[8] ^ det[4]);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      det     <= '0;
      detFill <= '0;
    end else if (!patActive) begin
      detFill <= '0;
    end else if (detValid) begin
      det <= {det[7:0], detBit};
      if (detFill != PRBS_FILL) begin
        detFill <= detFill + 4'd1;
      end
    end
  end

  // Data paths
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lineTxValid  <= 1'b0;
      lineTxBit    <= 1'b0;
      lineTxFramed <= 1'b0;
    end else if (loopMode == LOOP_M1) begin
      lineTxValid  <= 1'b0;
      lineTxBit    <= 1'b0;
      lineTxFramed <= 1'b0;
    end else if (remoteLoopActive || loopMode == LOOP_M2) begin
      lineTxValid  <= lineRxValid;
      lineTxBit    <= lineRxBit;
      lineTxFramed <= framedNow;
    end else if (patActive) begin
      lineTxValid  <= lineTxStrobe;
      lineTxBit    <= genBit;
      lineTxFramed <= 1'b0;
    end else begin
      lineTxValid  <= dteTxValid;
      lineTxBit    <= dteTxBit;
      lineTxFramed <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dteRxValid <= 1'b0;
      dteRxBit   <= 1'b0;
    end else if (loopMode == LOOP_M1 && patActive) begin
      dteRxValid <= 1'b0;
      dteRxBit   <= 1'b0;
    end else if (loopMode != LOOP_NONE) begin
      dteRxValid <= dteTxValid;
      dteRxBit   <= dteTxBit;
    end else begin
      // Unframed traffic never reaches the terminal
      dteRxValid <= lineRxValid && framedNow;
      dteRxBit   <= lineRxBit;
    end
  end

  // Error lamp: lit until 100 ms after the last error, steady blink after pattern timeout
  assign crcEvt = crcErr && !patActive;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lampMs         <= '0;
      lampOn         <= 1'b0;
      errorIndicator <= 1'b0;
    end else begin
      if (patTimedOut) begin
        if (tick) begin
          lampMs <= (lampMs >= BLINK_MS - 16'd1) ? '0 : lampMs + 16'd1;
          if (lampMs >= BLINK_MS - 16'd1) begin
            lampOn <= !lampOn;
          end
        end
      end else if (crcEvt || bitErr) begin
        lampOn <= 1'b1;
        lampMs <= '0;
      end else if (lampOn && tick) begin
        // A burst of errors merges into one long flash
        lampMs <= lampMs + 16'd1;
        if (lampMs >= FLASH_MS - 16'd1) begin
          lampOn <= 1'b0;
          lampMs <= '0;
        end
      end
      errorIndicator <= lampOn;
    end
  end
endmodule
`default_nettype wire

//--- sim/dls_partner.sv
// Far-end card model: packet pulses every 8 cycles and bit strobes.
// Assumes the mclk domain of the supervisor.
`timescale 1ns/1ns
`default_nettype none
module dls_partner (
  input  wire logic mclk,         // Clock
  input  wire logic rst,          // Reset, high
  input  wire logic sendFramed,   // Far end frames its packets
  output logic      lineRxPkt,    // Packet pulse
  output logic      lineRxFramed, // Framing flag
  output logic      lineRxValid,  // Bit strobe
  output logic      lineRxBit,    // Bit
  output logic      lineTxStrobe  // Transmit slot
);
  logic [2:0] phase;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {phase, lineRxPkt, lineRxFramed, lineRxValid, lineRxBit, lineTxStrobe} <= '0;
    end else begin
      phase <= phase + 3'h1;
      lineRxPkt <= (phase == 3'h0);
      // Flag means nothing between pulses, so it is scrambled there
      lineRxFramed <= (phase == 3'h0) ? sendFramed : ~lineRxFramed;
      lineRxValid <= phase[0];
      lineRxBit <= ~lineRxBit;
      // Even phase, so a transmit slot never meets a receive strobe
      lineTxStrobe <= (phase == 3'h4);
    end
  end
endmodule
`default_nettype wire

//--- sim/dls_supervisor_asserts.sv
// Port checker for the link supervisor.
// Assumes pattern and loop requests come from the panel inputs.
`timescale 1ns/1ns
`default_nettype none
module dls_supervisor_asserts (
  input wire logic mclk,            // Clock
  input wire logic rst,             // Reset
  input wire logic clearToSend,     // CTS
  input wire logic carrierDetect,   // CD
  input wire logic lineRxPkt,       // Packet
  input wire logic lineRxFramed,    // Framed
  input wire logic linkRestart,     // Restart
  input wire logic noLinkIndicator, // Link down
  input wire logic swLocalLoop,     // Loop switch
  input wire logic swPattern,       // Pattern switch
  input wire logic testMode,        // Test lamp
  input wire logic dteTxValid,      // Dte tx
  input wire logic dteTxBit,        // Dte bit
  input wire logic dteRxValid,      // Dte rx
  input wire logic dteRxBit,        // Dte rx bit
  input wire logic lineTxStrobe,    // Tx slot
  input wire logic lineRxValid,     // Rx strobe
  input wire logic lineTxValid,     // Tx strobe
  input wire logic lineTxFramed,    // Tx framed
  input wire logic crcErr,          // Crc
  input wire logic errorIndicator   // Error lamp
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_cts_cd; clearToSend == carrierDetect; endproperty
  property p_cts_drop; lineRxPkt && !lineRxFramed |-> ##[1:2] !clearToSend; endproperty
  property p_restart; linkRestart |=> !linkRestart ##[0:1] noLinkIndicator; endproperty
  property p_loop; $rose(swLocalLoop) && !swPattern |-> ##[1:2] testMode; endproperty
  sequence s_mode1; swLocalLoop && noLinkIndicator && testMode; endsequence
  property p_m1_dte;
    s_mode1 ##0 (!swPattern && !$past(swPattern) && dteTxValid)
      |=> dteRxValid && dteRxBit == $past(dteTxBit);
  endproperty
  property p_m1_quiet; s_mode1 |-> !clearToSend && !lineTxValid; endproperty
  property p_pat;
    lineTxValid && $past(lineTxStrobe) && !$past(dteTxValid) && !$past(lineRxValid)
      |-> !lineTxFramed;
  endproperty
  property p_crc; crcErr && !swPattern && !testMode |-> ##2 errorIndicator; endproperty
  a_cts_cd: assert property (p_cts_cd) else $error("cts and cd differ");
  a_cts_drop: assert property (p_cts_drop) else $error("cts held");
  a_restart: assert property (p_restart) else $error("bad restart");
  a_loop: assert property (p_loop) else $error("no test mode");
  a_m1_dte: assert property (p_m1_dte) else $error("no local echo");
  a_m1_quiet: assert property (p_m1_quiet) else $error("mode 1 active");
  a_pat: assert property (p_pat) else $error("pattern framed");
  a_crc: assert property (p_crc) else $error("no error flash");
  c_restart: cover property (linkRestart);
  c_test: cover property ($rose(testMode));
  c_crc: cover property (crcErr ##2 errorIndicator);
endmodule
bind dls_supervisor dls_supervisor_asserts u_chk (.*);
`default_nettype wire

//--- sim/test_dls_supervisor.sv
// Bench for the link supervisor, with a far-end card model.
// Assumes a 1-cycle tick so every second is 1000 cycles.
`timescale 1ns/1ns
`default_nettype none
module test_dls_supervisor;
  import dls_pkg::*;
  localparam int TK = 1;
  logic mclk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, x;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic swLocalLoop, dteLocalLoop, swRemoteLoop, dteRemoteLoop, swPattern, swPatternErr;
  logic remoteLoopActive, lineRxPkt, lineRxFramed, crcErr, lineRxValid, lineRxBit;
  logic lineTxStrobe, dteTxValid, dteTxBit, lineTxValid, lineTxBit, lineTxFramed;
  logic dteRxValid, dteRxBit, clearToSend, carrierDetect, noLinkIndicator, errorIndicator;
  logic testMode, remoteLoopbackRequest, linkRestart, irq, sendFramed;
  int failures, nTests;
  dls_supervisor #(.TICK_CYCLES(TK)) uut (.*);
  dls_partner far (.*);
  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    nTests++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && nTests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge mclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    {x, rs} = {s_axi_rdata, s_axi_rresp};
  endtask
  task automatic send(input logic b);
    @(posedge mclk);
    {dteTxValid, dteTxBit} <= {1'b1, b};
    @(posedge mclk);
    dteTxValid <= 1'b0;
    #1;
  endtask
  task automatic t_link();
    @(posedge mclk);
    sendFramed <= 1'b1;
    while (noLinkIndicator !== 1'b0) @(posedge mclk);
    cyc(4);
    chk(clearToSend, 1);
    chk(irq, 1);
    rd_reg(ADDR_IRQ_STAT);
    chk(x, 32'h10);
    cyc(3);
    chk(irq, 0);
  endtask
  task automatic t_crc();
    @(posedge mclk);
    crcErr <= 1'b1;
    @(posedge mclk);
    crcErr <= 1'b0;
    cyc(1);
    chk(errorIndicator, 1);
    chk(irq, 0);
    rd_reg(ADDR_IRQ_STAT);
    chk(x, 32'h2);
  endtask
  task automatic t_mode2();
    @(posedge mclk);
    dteLocalLoop <= 1'b1;
    cyc(3);
    chk({testMode, noLinkIndicator}, 2'b10);
    @(posedge mclk);
    swPattern <= 1'b1;
    cyc(3);
    rd_reg(ADDR_STATUS);
    chk(x & 32'h1c, 32'h8);
    cyc(1);
    x = {lineRxValid, lineRxBit};
    cyc(1);
    chk({lineTxValid, lineTxBit}, x[1:0]);
    @(posedge mclk);
    {dteLocalLoop, swPattern} <= 2'h0;
    cyc(3);
    rd_reg(ADDR_STATUS);
    chk({x[3:0] & 4'hd, noLinkIndicator}, 5'h2);
    @(posedge mclk);
    swPattern <= 1'b1;
    cyc(1);
    while (lineTxValid !== 1'b1) cyc(1);
    chk(lineTxFramed, 0);
    @(posedge mclk);
    {swPattern, remoteLoopActive, swRemoteLoop} <= 3'h3;
    cyc(3);
    chk({remoteLoopbackRequest, testMode}, 2'h3);
    repeat (2) begin
      x = {lineRxValid, lineRxBit};
      cyc(1);
      chk({lineTxValid, lineTxBit}, x[1:0]);
    end
    @(posedge mclk);
    {remoteLoopActive, swRemoteLoop} <= 2'h0;
  endtask
  task automatic t_restart();
    int n;
    n = 0;
    @(posedge mclk);
    sendFramed <= 1'b0;
    while (linkRestart !== 1'b1) begin
      @(posedge mclk);
      n++;
    end
    chk(n > LIM_DATA * TK - 5 && n < LIM_DATA * TK + 20, 1);
    cyc(2);
    chk({noLinkIndicator, clearToSend, irq}, 3'b101);
    rd_reg(ADDR_IRQ_STAT);
    chk(x, 32'h1);
  endtask
  task automatic t_mode1();
    int n;
    logic e0;
    n = 0;
    @(posedge mclk);
    {swLocalLoop, sendFramed} <= 2'h3;
    cyc(3);
    chk({testMode, clearToSend, lineTxValid}, 3'b100);
    send(1'b1);
    chk({dteRxValid, dteRxBit}, 2'b11);
    @(posedge mclk);
    {swPattern, swPatternErr} <= 2'h3;
    send(1'b1);
    chk(dteRxValid, 0);
    while (irq !== 1'b1) begin
      @(posedge mclk);
      n++;
    end
    chk(n > LIM_PAT_TO * TK - 20 && n < LIM_PAT_TO * TK + 5, 1);
    rd_reg(ADDR_IRQ_STAT);
    chk(x, 32'hc);
    rd_reg(ADDR_STATUS);
    chk(x & 32'h3c, 32'h24);
    cyc(10);
    e0 = errorIndicator;
    cyc(250 * TK);
    chk(errorIndicator ^ e0, 1);
    @(posedge mclk);
    {swPattern, swPatternErr} <= 2'h0;
    cyc(300 * TK);
    chk(errorIndicator, 0);
    @(posedge mclk);
    swLocalLoop <= 1'b0;
    t_link();
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    {swLocalLoop, dteLocalLoop, swRemoteLoop, dteRemoteLoop, swPattern} = '0;
    {swPatternErr, remoteLoopActive, crcErr, dteTxValid, dteTxBit, sendFramed} = '0;
    rst = 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    wr_reg(ADDR_IRQ_MASK, 32'h19);
    chk(rs, RESP_OKAY);
    wr_reg(4'h2, 32'h0);
    chk(rs, RESP_SLVERR);
    rd_reg(ADDR_IRQ_MASK);
    chk(x, 32'h19);
    rd_reg(4'h2);
    chk(rs, RESP_SLVERR);
    t_link();
    t_crc();
    t_mode2();
    t_restart();
    t_mode1();
    complete_run();
  end
  initial begin
    repeat (80000) @(posedge mclk);
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
